// >>> hw/dpm_pkg.sv
// Package of register map, field layout and code tables for the debug probe multiplexer.
package dpm_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] DPM_DIG_CFG  = 8'h00;
  localparam logic [7:0] DPM_ANA_CFG  = 8'h04;
  localparam logic [7:0] DPM_DAC_LVL  = 8'h08;
  localparam logic [7:0] DPM_SP_SEL   = 8'h0C;
  localparam logic [7:0] DPM_STATUS   = 8'h10;
  localparam logic [7:0] DPM_LOAD     = 8'h14;
  localparam logic [7:0] DPM_IBUF     = 8'h40;
  localparam logic [7:0] DPM_OBUF     = 8'h60;
  localparam logic [7:0] DPM_BUF_MASK = 8'hE0;
  // ----------------------------------------------------------------
  // Sizes and field positions
  // ----------------------------------------------------------------
  localparam int          DPM_NPIN     = 4;
  localparam int          DPM_NANA     = 2;
  localparam int          DPM_NGRP     = 7;
  localparam int          DPM_SW       = 10;
  localparam int          DPM_BUF_AW   = 3;
  localparam int          DPM_DIS_BIT  = 16;
  localparam int          DPM_ST_REJ   = 5;
  localparam int          DPM_ST_BUSY  = 4;
  localparam int          DPM_ANA_FLD  = 4;
  localparam logic [3:0]  DPM_SIG_CLK  = 4'h8;
  localparam logic [2:0]  DPM_ANA_MAX  = 3'h4;
  localparam logic [1:0]  DPM_SP_MAX   = 2'h2;
  localparam logic [1:0]  DPM_LD_LAST  = 2'h2;
  // ----------------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------------
  localparam logic [7:0] DPM_GRP_CODE [DPM_NGRP] =
    '{8'h01, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73};
  localparam logic [7:0] DPM_GRP_MASK [DPM_NGRP] =
    '{8'hFF, 8'h03, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hC7};
  typedef enum logic [2:0] {
    DPM_A_DAC, DPM_A_RAW_Q, DPM_A_RAW_I, DPM_A_FLT_Q, DPM_A_FLT_I
  } dpm_ana_t;
  typedef enum logic [1:0] {DPM_SRC_ADC, DPM_SRC_TXENV, DPM_SRC_SIGNAL_INPUT} dpm_src_t;
  typedef enum {DPM_LD_IDLE, DPM_LD_REQ, DPM_LD_CAPT} dpm_ld_t;
endpackage

// >>> hw/dpm_probe_mux.sv
// Debug probe multiplexer with APB registers, profile loader and host buffers.
//
// Notes on behaviour
// - at most two analog, four digital probes.
// - digital command first byte picks signal group.
// - low nibble picks signal; 8 is clock.
// - high nibble picks pin; codes above 3 reserved.
// - group codes 01,1B,1D,30,58,70,73.
// - clock group selections 0 to 7 valid.
// - encoder group: only 0 and 1 valid.
// - timer group: 2 to 7 valid.
// - card-mode group: 0 to 7 valid.
// - transceive group: 0 to 7 valid.
// - receiver data group: 0 to 7 valid.
// - receiver error group: 0,1,2,6,7 valid.
// - analog probes only on busy and aux-two.
// - analog codes 0 to 4, rest reserved.
// - raw I/Q source from processor input select.
// - analog probes are live samples to DAC.
// - separate independent input and output buffers.
// - registers written by host or profile load.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
module dpm_probe_mux
  import dpm_pkg::*;
(
  input  wire logic                              CLK,
  input  wire logic                              RESET_N,
  input  wire logic                              CE,
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [7:0]                        PADDR,
  input  wire logic [31:0]                       PWDATA,
  output logic                                   PREADY,
  output logic [31:0]                            PRDATA,
  output logic                                   PSLVERR,
  input  wire logic                              CLK_13M56,
  input  wire logic [7:0]                        DBG_CLOCKS,
  input  wire logic [7:0]                        DBG_TXENC,
  input  wire logic [7:0]                        DBG_TIMERS,
  input  wire logic [7:0]                        DBG_CARD,
  input  wire logic [7:0]                        DBG_TRANSCEIVE,
  input  wire logic [7:0]                        DBG_RXDATA,
  input  wire logic [7:0]                        DBG_RXERR,
  output logic [dpm_pkg::DPM_NPIN-1:0]           DPROBE,
  output logic [dpm_pkg::DPM_NPIN-1:0]           DPROBE_EN,
  input  wire logic [dpm_pkg::DPM_SW-1:0]        ADC_I,
  input  wire logic [dpm_pkg::DPM_SW-1:0]        ADC_Q,
  input  wire logic [dpm_pkg::DPM_SW-1:0]        TXENV_SAMPLE,
  input  wire logic [dpm_pkg::DPM_SW-1:0]        SIGNAL_INPUT_I,
  input  wire logic [dpm_pkg::DPM_SW-1:0]        SIGNAL_INPUT_Q,
  input  wire logic [dpm_pkg::DPM_SW-1:0]        FILT_I,
  input  wire logic [dpm_pkg::DPM_SW-1:0]        FILT_Q,
  output logic [dpm_pkg::DPM_SW-1:0]             DAC_BUSY,
  output logic [dpm_pkg::DPM_SW-1:0]             DAC_AUXILIARY_OUT_TWO,
  output logic                                   ANA_BUSY_EN,
  output logic                                   ANA_AUXILIARY_OUT_TWO_EN,
  output logic                                   EE_RD,
  output logic [7:0]                             EE_ADDR,
  input  wire logic [31:0]                       EE_DATA,
  input  wire logic [dpm_pkg::DPM_BUF_AW-1:0]    IBUF_RADDR,
  output logic [31:0]                            IBUF_RDATA,
  input  wire logic                              OBUF_WE,
  input  wire logic [dpm_pkg::DPM_BUF_AW-1:0]    OBUF_WADDR,
  input  wire logic [31:0]                       OBUF_WDATA
);
  import dpm_pkg::*;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic                    pready_reg;
  logic [31:0]             prdata_reg;
  logic                    pslverr_reg;
  logic                    acc;
  logic                    wr_fire;
  logic                    is_ibuf;
  logic                    is_obuf;
  logic [DPM_BUF_AW-1:0]   buf_idx;

  // The answer comes one cycle into the access phase; data is latched at the
  // first access edge so it is stable for the whole time PREADY stands.
  assign acc     = PSEL && PENABLE && !pready_reg;
  assign wr_fire = PSEL && PENABLE && pready_reg && PWRITE;
  assign is_ibuf = (PADDR & DPM_BUF_MASK) == DPM_IBUF;
  assign is_obuf = (PADDR & DPM_BUF_MASK) == DPM_OBUF;
  assign buf_idx = PADDR[DPM_BUF_AW+1:2];

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic [15:0]             dig_last_reg;
  logic [2:0]              pin_grp_reg [DPM_NPIN];
  logic [3:0]              pin_sig_reg [DPM_NPIN];
  logic [DPM_NPIN-1:0]     pin_en_reg;
  logic [7:0]              ana_cfg_reg;
  logic [DPM_SW-1:0]       dac_lvl_reg;
  logic [1:0]              sp_sel_reg;
  logic                    reject_reg;
  logic [31:0]             ibuf_mem [2**DPM_BUF_AW];
  logic [31:0]             obuf_mem [2**DPM_BUF_AW];

  // Digital command decode.
  logic [7:0]              cmd_grp;
  logic [3:0]              cmd_sig;
  logic [3:0]              cmd_pin;
  logic [2:0]              grp_idx;
  logic                    grp_ok;
  logic                    sig_ok;
  logic                    dig_ok;
  logic                    dig_wr;
  logic                    dig_dis;

  assign cmd_grp = PWDATA[7:0];
  assign cmd_sig = PWDATA[11:8];
  assign cmd_pin = PWDATA[15:12];
  assign dig_dis = PWDATA[DPM_DIS_BIT];
  assign dig_wr  = wr_fire && (PADDR == DPM_DIG_CFG);

  always_comb
  begin
    grp_idx = 3'h0;
    grp_ok  = 1'b0;
    for (int g = 0; g < DPM_NGRP; g++)
    begin
      if (cmd_grp == DPM_GRP_CODE[g])
      begin
        grp_idx = 3'(g);
        grp_ok  = 1'b1;
      end
    end
  end

  // Per-group valid masks reject reserved selections.
  assign sig_ok = (cmd_sig == DPM_SIG_CLK) ||
                  (!cmd_sig[3] && DPM_GRP_MASK[grp_idx][cmd_sig[2:0]]);
  assign dig_ok = (cmd_pin < 4'(DPM_NPIN)) && (dig_dis || (grp_ok && sig_ok));

  // Analog command decode.
  logic                    ana_wr;
  logic                    ana_ok;
  logic                    sp_wr;
  logic                    sp_ok;

  assign ana_wr = wr_fire && (PADDR == DPM_ANA_CFG);
  assign ana_ok = (PWDATA[2:0] <= DPM_ANA_MAX) &&
                  (PWDATA[DPM_ANA_FLD+2:DPM_ANA_FLD] <= DPM_ANA_MAX);
  assign sp_wr  = wr_fire && (PADDR == DPM_SP_SEL);
  assign sp_ok  = PWDATA[1:0] <= DPM_SP_MAX;

  // ----------------------------------------------------------------
  // Profile loader
  // ----------------------------------------------------------------
  dpm_ld_t                 ld_state_reg;
  logic [1:0]              ld_cnt_reg;
  logic [7:0]              ee_addr_reg;
  logic                    ee_rd_reg;
  logic                    ld_busy;
  logic                    ld_capt;

  assign ld_busy = ld_state_reg != DPM_LD_IDLE;
  assign ld_capt = ld_state_reg == DPM_LD_CAPT;

  // Three consecutive EEPROM words are copied: analog setup, DAC level and
  // processor input select. Data is expected one cycle after the read strobe.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ld_state_reg <= DPM_LD_IDLE;
      ld_cnt_reg   <= 2'h0;
      ee_addr_reg  <= 8'h00;
      ee_rd_reg    <= 1'b0;
    end
    else if (CE)
    begin
      ee_rd_reg <= 1'b0;
      unique case (ld_state_reg)
        DPM_LD_IDLE:
        begin
          if (wr_fire && (PADDR == DPM_LOAD))
          begin
            ee_addr_reg  <= PWDATA[7:0];
            ee_rd_reg    <= 1'b1;
            ld_cnt_reg   <= 2'h0;
            ld_state_reg <= DPM_LD_REQ;
          end
        end
        DPM_LD_REQ:
        begin
          ld_state_reg <= DPM_LD_CAPT;
        end
        DPM_LD_CAPT:
        begin
          if (ld_cnt_reg == DPM_LD_LAST)
          begin
            ld_state_reg <= DPM_LD_IDLE;
          end
          else
          begin
            ld_cnt_reg   <= ld_cnt_reg + 2'h1;
            ee_addr_reg  <= ee_addr_reg + 8'h01;
            ee_rd_reg    <= 1'b1;
            ld_state_reg <= DPM_LD_REQ;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // A load owns the analog registers in its capture cycles; a host write in the same
  // cycle loses, since the profile is the authoritative protocol setup.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ana_cfg_reg <= 8'h00;
      dac_lvl_reg <= '0;
      sp_sel_reg  <= 2'h0;
    end
    else if (CE)
    begin
      if (ld_capt)
      begin
        if (ld_cnt_reg == 2'h0 && EE_DATA[2:0] <= DPM_ANA_MAX &&
            EE_DATA[DPM_ANA_FLD+2:DPM_ANA_FLD] <= DPM_ANA_MAX)
        begin
          ana_cfg_reg <= EE_DATA[7:0];
        end
        if (ld_cnt_reg == 2'h1)
        begin
          dac_lvl_reg <= EE_DATA[DPM_SW-1:0];
        end
        if (ld_cnt_reg == DPM_LD_LAST && EE_DATA[1:0] <= DPM_SP_MAX)
        begin
          sp_sel_reg <= EE_DATA[1:0];
        end
      end
      else
      begin
        if (ana_wr && ana_ok)
        begin
          ana_cfg_reg <= PWDATA[7:0];
        end
        if (wr_fire && PADDR == DPM_DAC_LVL)
        begin
          dac_lvl_reg <= PWDATA[DPM_SW-1:0];
        end
        if (sp_wr && sp_ok)
        begin
          sp_sel_reg <= PWDATA[1:0];
        end
      end
    end
  end

  // Reject flag: set by any refused command, cleared by writing one; set wins.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      reject_reg   <= 1'b0;
      dig_last_reg <= 16'h0000;
    end
    else if (CE)
    begin
      if ((dig_wr && !dig_ok) || (ana_wr && !ana_ok) || (sp_wr && !sp_ok))
      begin
        reject_reg <= 1'b1;
      end
      else if (wr_fire && PADDR == DPM_STATUS && PWDATA[DPM_ST_REJ])
      begin
        reject_reg <= 1'b0;
      end
      if (dig_wr && dig_ok)
      begin
        dig_last_reg <= PWDATA[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Digital probe pins
  // ----------------------------------------------------------------
  logic [7:0]              grp_vec [DPM_NGRP];

  assign grp_vec = '{DBG_CLOCKS, DBG_TXENC, DBG_TIMERS, DBG_CARD,
                     DBG_TRANSCEIVE, DBG_RXDATA, DBG_RXERR};

  // One selection per pin, so no more than four digital probes exist.
  for (genvar p = 0; p < DPM_NPIN; p++)
  begin : g_pin
    always_ff @(posedge CLK)
    begin
      if (!RESET_N)
      begin
        pin_grp_reg[p] <= 3'h0;
        pin_sig_reg[p] <= 4'h0;
        pin_en_reg[p]  <= 1'b0;
        DPROBE[p]      <= 1'b0;
      end
      else if (CE)
      begin
        if (dig_wr && dig_ok && cmd_pin == 4'(p))
        begin
          pin_grp_reg[p] <= grp_idx;
          pin_sig_reg[p] <= cmd_sig;
          pin_en_reg[p]  <= !dig_dis;
        end
        if (!pin_en_reg[p])
        begin
          DPROBE[p] <= 1'b0;
        end
        else if (pin_sig_reg[p] == DPM_SIG_CLK)
        begin
          DPROBE[p] <= CLK_13M56;
        end
        else
        begin
          DPROBE[p] <= grp_vec[pin_grp_reg[p]][pin_sig_reg[p][2:0]];
        end
      end
    end
  end

  // The aux-two pin is surrendered to the digital path only when no analog
  // probe claims it.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      DPROBE_EN <= '0;
    end
    else if (CE)
    begin
      DPROBE_EN <= pin_en_reg & ~{1'b0, ana_cfg_reg[DPM_ANA_FLD+3], 2'b00};
    end
  end

  // ----------------------------------------------------------------
  // Analog probes
  // ----------------------------------------------------------------
  logic [DPM_SW-1:0]       raw_i;
  logic [DPM_SW-1:0]       raw_q;
  logic [DPM_SW-1:0]       ana_out [DPM_NANA];

  always_comb
  begin
    unique case (dpm_src_t'(sp_sel_reg))
      DPM_SRC_ADC:
      begin
        raw_i = ADC_I;
        raw_q = ADC_Q;
      end
      DPM_SRC_TXENV:
      begin
        raw_i = TXENV_SAMPLE;
        raw_q = TXENV_SAMPLE;
      end
      default:
      begin
        raw_i = SIGNAL_INPUT_I;
        raw_q = SIGNAL_INPUT_Q;
      end
    endcase
  end

  // Only the busy pin and aux-two carry analog samples.
  for (genvar a = 0; a < DPM_NANA; a++)
  begin : g_ana
    always_comb
    begin
      unique case (dpm_ana_t'(ana_cfg_reg[a*DPM_ANA_FLD +: 3]))
        DPM_A_DAC:   ana_out[a] = dac_lvl_reg;
        DPM_A_RAW_Q: ana_out[a] = raw_q;
        DPM_A_RAW_I: ana_out[a] = raw_i;
        DPM_A_FLT_Q: ana_out[a] = FILT_Q;
        default:     ana_out[a] = FILT_I;
      endcase
    end
  end

  // Samples are refreshed every enabled cycle for real-time viewing.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      DAC_BUSY    <= '0;
      DAC_AUXILIARY_OUT_TWO    <= '0;
      ANA_BUSY_EN <= 1'b0;
      ANA_AUXILIARY_OUT_TWO_EN <= 1'b0;
    end
    else if (CE)
    begin
      DAC_BUSY    <= ana_out[0];
      DAC_AUXILIARY_OUT_TWO    <= ana_out[1];
      ANA_BUSY_EN <= ana_cfg_reg[3];
      ANA_AUXILIARY_OUT_TWO_EN <= ana_cfg_reg[DPM_ANA_FLD+3];
    end
  end

  // ----------------------------------------------------------------
  // Host buffers
  // ----------------------------------------------------------------
  // Input and output buffers have separate arrays and ports, so host
  // traffic on one never stalls the core on the other.
  always_ff @(posedge CLK)
  begin
    if (CE && wr_fire && is_ibuf)
    begin
      ibuf_mem[buf_idx] <= PWDATA;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (CE && OBUF_WE)
    begin
      obuf_mem[OBUF_WADDR] <= OBUF_WDATA;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      IBUF_RDATA <= 32'h0;
    end
    else if (CE)
    begin
      IBUF_RDATA <= ibuf_mem[IBUF_RADDR];
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end
    else if (CE)
    begin
      pready_reg  <= acc;
      pslverr_reg <= 1'b0;
      if (acc)
      begin
        prdata_reg <= 32'h0;
        if (is_ibuf)
          prdata_reg <= ibuf_mem[buf_idx];
        else if (is_obuf)
          prdata_reg <= obuf_mem[buf_idx];
        else
        begin
          unique case (PADDR)
            DPM_DIG_CFG: prdata_reg <= {16'h0, dig_last_reg};
            DPM_ANA_CFG: prdata_reg <= {24'h0, ana_cfg_reg};
            DPM_DAC_LVL: prdata_reg <= {22'h0, dac_lvl_reg};
            DPM_SP_SEL:  prdata_reg <= {30'h0, sp_sel_reg};
            DPM_STATUS:  prdata_reg <= {26'h0, reject_reg, ld_busy, pin_en_reg};
            DPM_LOAD:    prdata_reg <= {24'h0, ee_addr_reg};
            default:     pslverr_reg <= 1'b1;
          endcase
        end
      end
    end
  end

  assign PREADY  = pready_reg;
  assign PRDATA  = prdata_reg;
  assign PSLVERR = pslverr_reg;
  assign EE_RD   = ee_rd_reg;
  assign EE_ADDR = ee_addr_reg;
endmodule

// >>> test/dpm_probe_mux_assertions.sv
// Concurrent checks on the ports of the debug probe multiplexer.
`timescale 1ns/1ns
module dpm_probe_mux_assertions
  import dpm_pkg::*;
(
  input wire logic                         CLK,
  input wire logic                         RESET_N,
  input wire logic                         CE,
  input wire logic                         PSEL,
  input wire logic                         PENABLE,
  input wire logic                         PREADY,
  input wire logic                         PSLVERR,
  input wire logic [dpm_pkg::DPM_NPIN-1:0] DPROBE_EN,
  input wire logic                         ANA_AUXILIARY_OUT_TWO_EN,
  input wire logic                         EE_RD,
  input wire logic [7:0]                   EE_ADDR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_READY_ONE: assert property (PREADY && CE |=> !PREADY)
    else $error("ready held longer than one cycle");
  AST_READY_TIME: assert property (CE && PSEL && PENABLE && !PREADY
    && $past(PSEL) && !$past(PENABLE) |=> PREADY)
    else $error("ready missing in second access cycle");
  AST_READY_CAUSE: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("ready outside an access phase");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY)
    else $error("slave error without ready");
  AST_EE_PULSE: assert property (EE_RD && CE |=> !EE_RD)
    else $error("profile read strobe longer than one cycle");
  AST_EE_STEP: assert property (EE_RD && $past(EE_RD, 2) |->
    EE_ADDR == $past(EE_ADDR, 2) + 8'h01)
    else $error("profile address did not advance by one");
  AST_LOAD_SEQ: assert property (EE_RD && !$past(EE_RD, 2) |-> ##2 EE_RD ##2 EE_RD)
    else $error("profile load did not fetch three words");
  AST_AUXILIARY_OUT_TWO_PRIO: assert property (ANA_AUXILIARY_OUT_TWO_EN && $past(ANA_AUXILIARY_OUT_TWO_EN) |-> !DPROBE_EN[2])
    else $error("digital and analog probes share the second auxiliary pin");
  AST_RESET_QUIET: assert property (!$past(RESET_N) |->
    !PREADY && !EE_RD && !ANA_AUXILIARY_OUT_TWO_EN && DPROBE_EN == 4'h0)
    else $error("outputs active straight after reset");
endmodule

bind dpm_probe_mux dpm_probe_mux_assertions u_chk (.CLK(CLK), .RESET_N(RESET_N), .CE(CE),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .DPROBE_EN(DPROBE_EN),
  .ANA_AUXILIARY_OUT_TWO_EN(ANA_AUXILIARY_OUT_TWO_EN), .EE_RD(EE_RD), .EE_ADDR(EE_ADDR));

// >>> test/dpm_host_model.sv
// Host controller model that issues configuration transfers over APB.
`timescale 1ns/1ns
module dpm_host_model
(
  input  wire logic        CLK,
  input  wire logic        PREADY,
  input  wire logic [31:0] PRDATA,
  input  wire logic        PSLVERR,
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic [7:0]       PADDR,
  output logic [31:0]      PWDATA
);
  initial
  begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
  end

  // Address and data are inverted on release so a stale bus never looks valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
      @(posedge CLK);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PADDR <= ~a;
    PWDATA <= ~d;
  endtask
endmodule

// >>> test/dpm_probe_mux_tb.sv
// Self-checking bench for the debug probe multiplexer.
`timescale 1ns/1ns
module dpm_probe_mux_tb;
  import dpm_pkg::*;
  logic        clk, reset_n, ce, psel, penable, pwrite, pready, pslverr, clk_13m56;
  logic        ana_busy_en, ana_auxiliary_out_two_en, ee_rd, obuf_we;
  logic [7:0]  paddr, ee_addr;
  logic [31:0] pwdata, prdata, ee_data, ibuf_rdata, obuf_wdata;
  logic [3:0]  dprobe, dprobe_en;
  logic [9:0]  dac_busy, dac_auxiliary_out_two;
  logic [2:0]  ibuf_raddr, obuf_waddr;
  logic [7:0]  dbg [7];
  logic [9:0]  smp [7];
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  localparam logic [7:0]  GROUP [7] = '{8'h01, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73};
  localparam logic [15:0] BAD [6] = '{16'h0002, 16'h021B, 16'h001D, 16'h0473, 16'h0901,
                                      16'h4001};

  // Stored profile words: analog routing, DAC level, processor input select.
  assign ee_data = (ee_addr == 8'h30) ? 32'h0000009A : (ee_addr == 8'h31) ? 32'h00000155 :
                   (ee_addr == 8'h32) ? 32'h00000001 : {24'hA5A5A5, ~ee_addr};

  dpm_probe_mux dut (
    .CLK(clk), .RESET_N(reset_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .CLK_13M56(clk_13m56), .DBG_CLOCKS(dbg[0]), .DBG_TXENC(dbg[1]),
    .DBG_TIMERS(dbg[2]), .DBG_CARD(dbg[3]), .DBG_TRANSCEIVE(dbg[4]), .DBG_RXDATA(dbg[5]),
    .DBG_RXERR(dbg[6]), .DPROBE(dprobe), .DPROBE_EN(dprobe_en), .ADC_I(smp[0]),
    .ADC_Q(smp[1]), .TXENV_SAMPLE(smp[2]), .SIGNAL_INPUT_I(smp[3]), .SIGNAL_INPUT_Q(smp[4]),
    .FILT_I(smp[5]), .FILT_Q(smp[6]), .DAC_BUSY(dac_busy), .DAC_AUXILIARY_OUT_TWO(dac_auxiliary_out_two),
    .ANA_BUSY_EN(ana_busy_en), .ANA_AUXILIARY_OUT_TWO_EN(ana_auxiliary_out_two_en), .EE_RD(ee_rd), .EE_ADDR(ee_addr),
    .EE_DATA(ee_data), .IBUF_RADDR(ibuf_raddr), .IBUF_RDATA(ibuf_rdata), .OBUF_WE(obuf_we),
    .OBUF_WADDR(obuf_waddr), .OBUF_WDATA(obuf_wdata));
  dpm_host_model host (.CLK(clk), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      failures++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, a, 32'h0, q, e);
    check(q, want);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [9:0] ana_exp(input int s, input int sp);
    case (s)
      0: return 10'h3A5;
      1: return (sp == 0) ? smp[1] : (sp == 1) ? smp[2] : smp[4];
      2: return (sp == 0) ? smp[0] : (sp == 1) ? smp[2] : smp[3];
      3: return smp[6];
      default: return smp[5];
    endcase
  endfunction

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A hang counts as a mismatch and goes straight to the verdict.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    logic [3:0]  s;
    logic [1:0]  p;
    logic [7:0]  m;
    logic        b;
    logic [31:0] q;
    logic        e;
    reset_n = 1'b0;
    ce = 1'b1;
    clk_13m56 = 1'b0;
    obuf_we = 1'b0;
    obuf_waddr = 3'h0;
    obuf_wdata = 32'h0;
    ibuf_raddr = 3'h0;
    foreach (dbg[j]) dbg[j] = 8'h00;
    foreach (smp[j]) smp[j] = 10'h000;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    // Only the selected bit carries the level, so a wrong group, bit or pin shows.
    for (int g = 0; g < 7; g++)
      for (int k = 0; k < 2; k++)
      begin
        s = (k == 1) ? 4'h8 : (g == 6) ? 4'h7 : 4'(g);
        p = 2'(g + k);
        m = (k == 1) ? 8'h00 : 8'h01 << s[2:0];
        wr(DPM_DIG_CFG, {16'h0, 2'b00, p, s, GROUP[g]});
        for (int v = 0; v < 2; v++)
        begin
          b = v[0];
          @(posedge clk);
          foreach (dbg[j]) dbg[j] <= (j == g) ? (b ? m : ~m) : (b ? 8'h00 : 8'hFF);
          clk_13m56 <= (k == 1) ? b : ~b;
          wait_cycles(3);
          check(32'(dprobe[p]), 32'(b));
          check(32'(dprobe_en[p]), 32'h1);
        end
      end
    rd(DPM_STATUS, 32'h0000000F);
    rd(DPM_DIG_CFG, 32'h00003873);
    foreach (BAD[i])
    begin
      wr(DPM_STATUS, 32'h00000020);
      wr(DPM_DIG_CFG, {16'h0, BAD[i]});
      rd(DPM_DIG_CFG, 32'h00003873);
      rd(DPM_STATUS, 32'h0000002F);
    end
    wr(DPM_STATUS, 32'h00000020);
    rd(DPM_STATUS, 32'h0000000F);
    wr(DPM_DAC_LVL, 32'h000003A5);
    for (int sp = 0; sp < 3; sp++)
    begin
      @(posedge clk);
      foreach (smp[j]) smp[j] <= 10'(j * 73 + sp * 11 + 5);
      wr(DPM_SP_SEL, 32'(sp));
      for (int s2 = 0; s2 < 5; s2++)
      begin
        wr(DPM_ANA_CFG, {24'h0, 1'b1, 3'(4 - s2), 1'b1, 3'(s2)});
        wait_cycles(3);
        check(32'(dac_busy), 32'(ana_exp(s2, sp)));
        check(32'(dac_auxiliary_out_two), 32'(ana_exp(4 - s2, sp)));
        check(32'({ana_busy_en, ana_auxiliary_out_two_en, dprobe_en[2]}), 32'h6);
      end
    end
    wr(DPM_ANA_CFG, 32'h0000000D);
    rd(DPM_ANA_CFG, 32'h0000008C);
    wr(DPM_SP_SEL, 32'h00000003);
    rd(DPM_SP_SEL, 32'h00000002);
    @(posedge clk);
    smp[5] <= 10'h2C9;
    wait_cycles(2);
    check(32'(dac_busy), 32'h000002C9);
    // Clock enable low must freeze the live sample.
    @(posedge clk);
    ce <= 1'b0;
    smp[5] <= 10'h0F0;
    wait_cycles(3);
    check(32'(dac_busy), 32'h000002C9);
    @(posedge clk);
    ce <= 1'b1;
    // The DAC write lands while the profile load runs and must be dropped.
    wr(DPM_LOAD, 32'h00000030);
    wr(DPM_DAC_LVL, 32'h00000011);
    wait_cycles(8);
    rd(DPM_ANA_CFG, 32'h0000009A);
    rd(DPM_DAC_LVL, 32'h00000155);
    rd(DPM_SP_SEL, 32'h00000001);
    check(32'({dac_busy, dac_auxiliary_out_two}), 32'({smp[2], smp[2]}));
    wr(DPM_IBUF + 8'h04, 32'hC0DE1234);
    rd(DPM_IBUF + 8'h04, 32'hC0DE1234);
    @(posedge clk);
    ibuf_raddr <= 3'h1;
    obuf_we <= 1'b1;
    obuf_waddr <= 3'h1;
    obuf_wdata <= 32'h5A5A0F0F;
    @(posedge clk);
    obuf_we <= 1'b0;
    wait_cycles(1);
    check(ibuf_rdata, 32'hC0DE1234);
    rd(DPM_OBUF + 8'h04, 32'h5A5A0F0F);
    wr(DPM_OBUF + 8'h04, 32'h00000000);
    rd(DPM_OBUF + 8'h04, 32'h5A5A0F0F);
    rd(DPM_IBUF + 8'h04, 32'hC0DE1234);
    host.xfer(1'b0, 8'h20, 32'h0, q, e);
    check(32'(e), 32'h1);
    tally_and_finish();
  end
endmodule
